// *** pkg/serial_fmt_regs.vh ***
// Register offsets, fields, reset values and timing counts for the serial output format block.
`ifndef SERIAL_FMT_REGS_VH
`define SERIAL_FMT_REGS_VH

`define CHAN_SEL_ADDR 8'h05
`define FMT_ADDR 8'h14
`define DRV_ADDR 8'h15
`define PHS_ADDR 8'h16

`define CHAN_SEL_RST 8'hFF
`define FMT_RST 8'h00
`define DRV_RST 8'h00
`define PHS_RST 8'h03
`define PHS_CODE_RST 4'h3

`define FMT_CODE_MSB 1
`define FMT_CODE_LSB 0
`define FMT_INV_BIT 2
`define FMT_LOWPWR_BIT 6
`define DRV_DOUBLE_BIT 0
`define DRV_TERM_MSB 5
`define DRV_TERM_LSB 4
`define PHS_CODE_MSB 3
`define PHS_CODE_LSB 0

`define FMT_OFFSET_BIN 2'h0
`define FMT_TWOS_COMP 2'h1
`define TERM_NONE 2'h0
`define PHS_CODE_MAX 4'hA

`define NUM_CHAN 8
`define SAMPLE_BITS 14
`define PHASE_STEP_DEG 60
`define FULL_TURN_DEG 360
`define STEPS_PER_BIT (`FULL_TURN_DEG / `PHASE_STEP_DEG)
`define STEP_CYCLES 1

`endif

// *** design/sample_formatter.v ***
// Shared sample number format and per-channel output inversion.
`timescale 1ns/100ps
`default_nettype none
`include "serial_fmt_regs.vh"

module sample_formatter (
    input wire sys_clk, // System clock.
    input wire resetn, // Asynchronous reset, active low.
    input wire latch_en, // One-cycle sample latch enable.
    input wire [`NUM_CHAN*`SAMPLE_BITS-1:0] raw_samples, // Offset binary samples.
    input wire [1:0] fmt_code, // Shared format code.
    input wire [`NUM_CHAN-1:0] invert_en, // Per-channel inversion.
    output reg [`NUM_CHAN*`SAMPLE_BITS-1:0] out_samples, // Formatted samples.
    output reg out_valid // Pulse when new samples stand.
);

    function [`SAMPLE_BITS-1:0] fmt_one;
        input [`SAMPLE_BITS-1:0] s;
        input [1:0] code;
        input inv;
        reg [`SAMPLE_BITS-1:0] t;
        begin
            t = s;
            if (code == `FMT_TWOS_COMP) begin
                t[`SAMPLE_BITS-1] = ~s[`SAMPLE_BITS-1];
            end
            fmt_one = inv ? ~t : t;
        end
    endfunction

    integer i;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            out_samples <= {(`NUM_CHAN*`SAMPLE_BITS){1'b0}};
            out_valid <= 1'b0;
        end else begin
            out_valid <= latch_en;
            if (latch_en) begin
                for (i = 0; i < `NUM_CHAN; i = i + 1) begin
                    out_samples[i*`SAMPLE_BITS +: `SAMPLE_BITS] <=
                        fmt_one(raw_samples[i*`SAMPLE_BITS +: `SAMPLE_BITS],
                                fmt_code, invert_en[i]);
                end
            end
        end
    end

endmodule
`default_nettype wire

// *** design/clock_phase_gen.v ***
// Bit clock divider with selectable output phase and word sync clock.
`timescale 1ns/100ps
`default_nettype none
`include "serial_fmt_regs.vh"

module clock_phase_gen (
    input wire sys_clk, // System clock.
    input wire resetn, // Asynchronous reset, active low.
    input wire [3:0] phase_code, // Output clock phase code.
    output reg latch_en, // Fixed-timing sample latch pulse.
    output reg bit_clock_out, // Phase-shifted output data clock.
    output reg word_sync_clock_out // Frame clock, aligned to data.
);

    // Reduces a phase code to a step within one bit period.
    function [2:0] steps_mod;
        input [3:0] code;
        reg [3:0] r;
        begin
            r = code;
            if (r >= 4'h6) begin
                r = r - 4'h6;
            end
            steps_mod = r[2:0];
        end
    endfunction

    reg [2:0] step_q;
    reg [3:0] bit_q;
    reg [2:0] rel;
    reg [2:0] shift;

    always @* begin
        shift = steps_mod(phase_code);
        if (step_q >= shift) begin
            rel = step_q - shift;
        end else begin
            rel = step_q + 3'd6 - shift;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            step_q <= 3'd0;
            bit_q <= 4'h0;
            latch_en <= 1'b0;
            bit_clock_out <= 1'b0;
            word_sync_clock_out <= 1'b0;
        end else begin
            if (step_q == 3'd5) begin
                step_q <= 3'd0;
                bit_q <= (bit_q == 4'hD) ? 4'h0 : bit_q + 4'h1;
            end else begin
                step_q <= step_q + 3'd1;
            end
            // Latching follows the unshifted step count only.
            latch_en <= (step_q == 3'd5) && (bit_q == 4'hD);
            bit_clock_out <= (rel < 3'd3);
            word_sync_clock_out <= (bit_q < 4'h7);
        end
    end

endmodule
`default_nettype wire

// *** design/serial_output_format_config.v ***
// Register bank shaping the serial sample outputs: format, drive and clock phase.
// Functional notes
// - Format field 00 is offset binary (reset), 01 twos complement.
// - Inversion bit 2 is per channel; other format bits are shared.
// - Clock double drive bit 0 is per channel; other drive bits shared.
// - Two-bit termination field sets swing internally; 00 none at reset.
// - Four-bit phase code, valid values 0000 through 1010.
// - Each phase step shifts the data clock 60 degrees; zero gives none.
// - Phase code resets to 0011, 180 degrees, register value 0x03.
// - Phase code selects which divider phase drives the data clock.
// - Changing phase never moves internal sample latch timing.
`timescale 1ns/100ps
`default_nettype none
`include "serial_fmt_regs.vh"

module serial_output_format_config (
    input wire sys_clk, // System clock, 100 MHz.
    input wire resetn, // Asynchronous reset, active low.
    input wire [7:0] addr, // Register address.
    input wire [7:0] wdata, // Write data.
    input wire wr_en, // Write strobe.
    input wire rd_en, // Read strobe.
    output reg [7:0] rdata, // Read data, cycle after the strobe.
    input wire [`NUM_CHAN*`SAMPLE_BITS-1:0] raw_samples, // Core samples.
    output wire [`NUM_CHAN*`SAMPLE_BITS-1:0] out_samples, // Formatted samples.
    output wire out_valid, // New formatted samples pulse.
    output wire bit_clock_out, // Output data clock.
    output wire word_sync_clock_out, // Output frame clock.
    output reg [`NUM_CHAN-1:0] clk_double_drive, // Per-channel 2x drive.
    output reg [1:0] term_sel, // Output termination code.
    output reg low_power_mode // Reduced swing output mode.
);

    reg [7:0] chan_sel_q;
    reg [7:0] fmt_shared_q;
    reg [`NUM_CHAN-1:0] invert_q;
    reg [7:0] drv_shared_q;
    reg [`NUM_CHAN-1:0] dbl_q;
    reg [3:0] phase_q;
    reg [7:0] rdata_d;
    reg [2:0] first_ch;
    integer k;
    integer n;

    // Per-channel bits read back from the lowest selected channel.
    always @* begin
        first_ch = 3'd0;
        for (k = `NUM_CHAN - 1; k >= 0; k = k - 1) begin
            if (chan_sel_q[k]) begin
                first_ch = k[2:0];
            end
        end
    end

    always @* begin
        case (addr)
            `CHAN_SEL_ADDR: rdata_d = chan_sel_q;
            `FMT_ADDR: begin
                rdata_d = fmt_shared_q;
                rdata_d[`FMT_INV_BIT] = invert_q[first_ch];
            end
            `DRV_ADDR: begin
                rdata_d = drv_shared_q;
                rdata_d[`DRV_DOUBLE_BIT] = dbl_q[first_ch];
            end
            `PHS_ADDR: rdata_d = {4'h0, phase_q};
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            chan_sel_q <= `CHAN_SEL_RST;
            fmt_shared_q <= `FMT_RST;
            invert_q <= {`NUM_CHAN{1'b0}};
            drv_shared_q <= `DRV_RST;
            dbl_q <= {`NUM_CHAN{1'b0}};
            phase_q <= `PHS_CODE_RST;
            rdata <= 8'h00;
        end else begin
            rdata <= rd_en ? rdata_d : 8'h00;
            if (wr_en) begin
                case (addr)
                    `CHAN_SEL_ADDR: chan_sel_q <= wdata;
                    `FMT_ADDR: begin
                        fmt_shared_q <= wdata & ~(8'h01 << `FMT_INV_BIT);
                        for (n = 0; n < `NUM_CHAN; n = n + 1) begin
                            if (chan_sel_q[n]) begin
                                invert_q[n] <= wdata[`FMT_INV_BIT];
                            end
                        end
                    end
                    `DRV_ADDR: begin
                        drv_shared_q <= wdata & ~(8'h01 << `DRV_DOUBLE_BIT);
                        for (n = 0; n < `NUM_CHAN; n = n + 1) begin
                            if (chan_sel_q[n]) begin
                                dbl_q[n] <= wdata[`DRV_DOUBLE_BIT];
                            end
                        end
                    end
                    `PHS_ADDR: begin
                        // Codes above the top valid value are ignored.
                        if (wdata[7:4] == 4'h0 && wdata[3:0] <= `PHS_CODE_MAX) begin
                            phase_q <= wdata[3:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clk_double_drive <= {`NUM_CHAN{1'b0}};
            term_sel <= `TERM_NONE;
            low_power_mode <= 1'b0;
        end else begin
            clk_double_drive <= dbl_q;
            term_sel <= drv_shared_q[`DRV_TERM_MSB:`DRV_TERM_LSB];
            low_power_mode <= fmt_shared_q[`FMT_LOWPWR_BIT];
        end
    end

    wire latch_en;

    clock_phase_gen i_clock_phase_gen (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .phase_code(phase_q),
        .latch_en(latch_en),
        .bit_clock_out(bit_clock_out),
        .word_sync_clock_out(word_sync_clock_out)
    );

    sample_formatter i_sample_formatter (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .latch_en(latch_en),
        .raw_samples(raw_samples),
        .fmt_code(fmt_shared_q[`FMT_CODE_MSB:`FMT_CODE_LSB]),
        .invert_en(invert_q),
        .out_samples(out_samples),
        .out_valid(out_valid)
    );

endmodule
`default_nettype wire

// *** dv/sofc_checker.sv ***
// Port assertions for the serial output format register bank.
`timescale 1ns/100ps
`default_nettype none
`include "serial_fmt_regs.vh"
module sofc_checker (
    input wire logic sys_clk, // clk
    input wire logic resetn, // rst
    input wire logic [7:0] addr, // addr
    input wire logic [7:0] wdata, // data
    input wire logic wr_en, // wr
    input wire logic rd_en, // rd
    input wire logic [7:0] rdata, // rdata
    input wire logic out_valid, // valid
    input wire logic word_sync_clock_out, // frame clk
    input wire logic [1:0] term_sel, // term
    input wire logic low_power_mode // low power
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!resetn);
property p_ph_max; rd_en && addr == `PHS_ADDR |=> rdata <= 8'h0A; endproperty
a_ph_max: assert property (p_ph_max) else $error("phase above max");
property p_ph_rdb; wr_en && addr == `PHS_ADDR && wdata <= 8'h0A ##1 rd_en && addr == `PHS_ADDR
    |=> rdata == $past(wdata, 2); endproperty
a_ph_rdb: assert property (p_ph_rdb) else $error("phase readback");
property p_fmt_rdb; wr_en && addr == `FMT_ADDR ##1 rd_en && addr == `FMT_ADDR
    |=> rdata[1:0] == $past(wdata[1:0], 2); endproperty
a_fmt_rdb: assert property (p_fmt_rdb) else $error("format readback");
property p_lowpwr; wr_en && addr == `FMT_ADDR
    |-> ##2 low_power_mode == $past(wdata[6], 2); endproperty
a_lowpwr: assert property (p_lowpwr) else $error("low power bit");
property p_term; wr_en && addr == `DRV_ADDR
    |-> ##2 term_sel == $past(wdata[5:4], 2); endproperty
a_term: assert property (p_term) else $error("termination field");
property p_vpulse; out_valid |=> !out_valid; endproperty
a_vpulse: assert property (p_vpulse) else $error("valid too long");
property p_vperiod; out_valid |-> ##84 out_valid; endproperty
a_vperiod: assert property (p_vperiod) else $error("latch period moved");
property p_speriod; $rose(word_sync_clock_out) |-> ##84 $rose(word_sync_clock_out); endproperty
a_speriod: assert property (p_speriod) else $error("frame period moved");
endmodule
bind serial_output_format_config sofc_checker i_sofc_checker (.sys_clk, .resetn, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .out_valid, .word_sync_clock_out, .term_sel, .low_power_mode);
`default_nettype wire

// *** dv/sample_receiver.sv ***
// Receiving logic model that captures each formatted sample word.
`timescale 1ns/100ps
`default_nettype none
`include "serial_fmt_regs.vh"
module sample_receiver (
    input wire logic sys_clk, // clk
    input wire logic resetn, // rst
    input wire logic [`NUM_CHAN*`SAMPLE_BITS-1:0] out_samples, // samples
    input wire logic out_valid, // valid
    output logic [`NUM_CHAN*`SAMPLE_BITS-1:0] rx_word_q, // captured
    output logic rx_new_q // capture pulse
);
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rx_word_q <= '0;
            rx_new_q <= 1'b0;
        end else begin
            rx_new_q <= out_valid;
            if (out_valid) rx_word_q <= out_samples;
        end
    end
endmodule
`default_nettype wire

// *** dv/test_serial_output_format_config.sv ***
// Self-checking bench for the serial output format register bank.
`timescale 1ns/100ps
`default_nettype none
`include "serial_fmt_regs.vh"
module test_serial_output_format_config;
localparam int W = `NUM_CHAN*`SAMPLE_BITS;
localparam int S = `SAMPLE_BITS;
logic sys_clk = 0, resetn = 0, wr_en = 0, rd_en = 0, rd_d1 = 0, ws_p = 0, bc_p = 0;
logic [7:0] addr = 0, wdata = 0, rdata, clk_double_drive;
logic [W-1:0] raw_samples = '0, out_samples, rx_word;
logic out_valid, bit_clock_out, word_sync_clock_out, low_power_mode, rx_new;
logic [1:0] term_sel;
logic [W-1:0] rq[$], sq[$];
int mismatches = 0, comparisons = 0, k, c, ph;
always #5 sys_clk = ~sys_clk;
serial_output_format_config i_serial_output_format_config (.sys_clk, .resetn, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .raw_samples, .out_samples, .out_valid, .bit_clock_out,
    .word_sync_clock_out, .clk_double_drive, .term_sel, .low_power_mode);
sample_receiver i_sample_receiver (.sys_clk, .resetn, .out_samples, .out_valid,
    .rx_word_q(rx_word), .rx_new_q(rx_new));
task automatic chk(input string n, input logic [W-1:0] s, x);
    comparisons++;
    if (s !== x) begin
        mismatches++;
        $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
endtask
task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask
task automatic bus(input logic w, input logic [7:0] a, d, x);
    @(posedge sys_clk);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wdata <= d;
    if (!w) rq.push_back(W'(x));
endtask
task automatic idle;
    @(posedge sys_clk);
    wr_en <= 0;
    rd_en <= 0;
endtask
// Waits for a rising edge of the frame clock or a capture pulse, within 200 cycles.
task automatic edge_wait(input logic sync);
    int i;
    i = 0;
    do begin
        @(posedge sys_clk);
        #1 i++;
    end while ((sync ? !(word_sync_clock_out && !ws_p) : rx_new !== 1) && i < 200);
    if (i >= 200) begin
        mismatches++;
        tally_and_finish;
    end
endtask
// Two captures pass so that the second one surely follows the new settings.
task automatic samp(input logic tc, input logic [7:0] inv);
    edge_wait(0);
    edge_wait(0);
    sq.push_back(fmt(raw_samples, tc, inv));
endtask
function automatic logic [W-1:0] fmt(input logic [W-1:0] r, input logic tc, input logic [7:0] v);
    int n;
    fmt = r;
    for (n = 0; n < `NUM_CHAN; n++) begin
        fmt[n*S+S-1] = fmt[n*S+S-1] ^ tc;
        if (v[n]) fmt[n*S+:S] = ~fmt[n*S+:S];
    end
endfunction
always @(posedge sys_clk) begin
    rd_d1 <= rd_en;
    ws_p <= word_sync_clock_out;
    bc_p <= bit_clock_out;
    if (rd_d1) chk("rdata", W'(rdata), rq.pop_front());
    if (rx_new === 1 && sq.size() > 0) chk("samples", rx_word, sq.pop_front());
end
initial begin
    void'($urandom(69));
    raw_samples <= W'({$urandom, $urandom, $urandom, $urandom});
    repeat (10) @(posedge sys_clk);
    resetn <= 1;
    bus(0, `FMT_ADDR, 0, `FMT_RST);
    bus(0, `DRV_ADDR, 0, `DRV_RST);
    bus(0, `PHS_ADDR, 0, `PHS_RST);
    bus(0, 8'h40, 0, 8'h00);
    idle;
    samp(0, 8'h00);
    $display("test reset values done");
    for (c = 0; c < 12; c++) begin
        ph = (c > 10) ? 10 : c;
        bus(1, `PHS_ADDR, 8'(c), 0);
        bus(0, `PHS_ADDR, 0, 8'(ph));
        idle;
        edge_wait(1);
        for (k = 0; !(bit_clock_out && !bc_p) && k < 8; k++) @(posedge sys_clk) #1;
        chk("phase", W'(k), W'(ph % 6));
    end
    $display("test phase codes done");
    @(posedge sys_clk);
    raw_samples <= W'({$urandom, $urandom, $urandom, $urandom});
    bus(1, `CHAN_SEL_ADDR, 8'h0F, 0);
    bus(1, `FMT_ADDR, 8'h45, 0);
    bus(1, `CHAN_SEL_ADDR, 8'hF0, 0);
    bus(1, `FMT_ADDR, 8'h41, 0);
    bus(0, `FMT_ADDR, 0, 8'h41);
    bus(1, `DRV_ADDR, 8'h31, 0);
    bus(0, `DRV_ADDR, 0, 8'h31);
    bus(1, `CHAN_SEL_ADDR, 8'h0F, 0);
    bus(0, `FMT_ADDR, 0, 8'h45);
    bus(0, `DRV_ADDR, 0, 8'h30);
    idle;
    samp(1, 8'h0F);
    chk("drive", W'({clk_double_drive, term_sel, low_power_mode}), W'(11'h787));
    repeat (3) idle;
    $display("test format and drive done");
    tally_and_finish;
end
endmodule
`default_nettype wire
